//--- rtl/encoder_capture_pkg.sv
// Constants, types and helpers for the encoder position capture block.
// Assumes one 250 MHz clock; every pin input is resynchronised before use.
package encoder_capture_pkg;

  localparam int NUM_TRACKERS = 5;
  localparam int NUM_SENSORS  = 4;
  localparam int CNT_W        = 32;

  // Address decode fields
  localparam logic [7:0] ADDR_FIXED_HI   = 8'hff;
  localparam logic [3:0] REGION_VECTOR   = 4'h2;
  localparam logic [3:0] REGION_STATUS   = 4'h3;
  localparam logic [3:0] REGION_TRACKER  = 4'h4;
  localparam logic [3:0] WORD_RESET_LAST = 4'h4;
  localparam logic [3:0] WORD_INT_ENABLE = 4'h6;
  localparam logic [3:0] WORD_RESET_ARM  = 4'h7;

  // Values after reset
  localparam logic [7:0] VECTOR_RESET     = 8'h0f;
  localparam logic       INT_ENABLE_RESET = 1'h0;

  // Input synchroniser: select and write strobe idle high
  localparam int         SYNC_W    = 83;
  localparam logic [82:0] SYNC_INIT = {2'h3, 81'h0};

  // Time base, counted in 10 KHz reference ticks
  localparam int          REF_TICK_HZ = 10000;
  localparam logic [5:0]  DIV_200HZ   = 6'(REF_TICK_HZ / 200);
  localparam logic [5:0]  HALF_200HZ  = 6'(REF_TICK_HZ / 400);
  localparam logic [3:0]  DIV_1KHZ    = 4'(REF_TICK_HZ / 1000);
  localparam logic [3:0]  HALF_1KHZ   = 4'(REF_TICK_HZ / 2000);
  localparam logic [13:0] DIV_1HZ     = 14'(REF_TICK_HZ);
  localparam logic [13:0] HALF_1HZ    = 14'(REF_TICK_HZ / 2);

  // Tracker arbiter states
  typedef enum logic [2:0] {
    ARB_IDLE,
    ARB_CLEAR,
    ARB_STEP,
    ARB_LATCH_INDEX,
    ARB_LATCH_PERIODIC,
    ARB_READ
  } arb_state_t;

  // Index sensor serving a tracker; sensor 0 serves trackers 0 and 1
  function automatic int sensor_of_tracker(input int t);
    return (t <= 1) ? 0 : t - 1;
  endfunction

  // Tracker whose direction is captured for a sensor
  function automatic int tracker_of_sensor(input int s);
    return (s == 0) ? 0 : s + 1;
  endfunction

endpackage

//--- rtl/encoder_tracker.sv
// One encoder tracker: up/down counter, two latches and the arbiter.
// Assumes all inputs are one-cycle pulses or levels in the clock domain.
`timescale 1ns/1ns
module encoder_tracker
  import encoder_capture_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             step_pulse,
  input  wire logic             step_up,
  input  wire logic             clear_pulse,
  input  wire logic             index_strobe,
  input  wire logic             periodic_strobe,
  input  wire logic             read_req,
  input  wire logic             latch_select,
  input  wire logic             read_release,
  output logic      [CNT_W-1:0] read_data,
  output logic                  read_oe,
  output logic                  read_done
);

  arb_state_t       state_r;
  arb_state_t       state_nxt;
  logic             clear_pend_r;
  logic             step_pend_r;
  logic             step_dir_r;
  logic             index_pend_r;
  logic             periodic_pend_r;
  logic             read_pend_r;
  logic             read_sel_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] present_r;
  logic [CNT_W-1:0] index_ref_r;

  // Pending requests; a new request wins over its own service
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_pend_r    <= 1'h0;
      step_pend_r     <= 1'h0;
      step_dir_r      <= 1'h0;
      index_pend_r    <= 1'h0;
      periodic_pend_r <= 1'h0;
      read_pend_r     <= 1'h0;
      read_sel_r      <= 1'h0;
    end else begin
      clear_pend_r    <= clear_pulse | (clear_pend_r & (state_r != ARB_CLEAR));
      step_pend_r     <= step_pulse | (step_pend_r & (state_r != ARB_STEP));
      index_pend_r    <= index_strobe | (index_pend_r & (state_r != ARB_LATCH_INDEX));
      periodic_pend_r <= periodic_strobe | (periodic_pend_r & (state_r != ARB_LATCH_PERIODIC));
      read_pend_r     <= read_req | (read_pend_r & (state_r != ARB_READ));
      if (step_pulse) begin
        step_dir_r <= step_up;
      end
      if (read_req) begin
        read_sel_r <= latch_select;
      end
    end
  end

  always_comb begin
    state_nxt = ARB_IDLE;
    unique case (state_r)
      ARB_IDLE: begin
        if (clear_pend_r) begin
          state_nxt = ARB_CLEAR;
        end else if (step_pend_r) begin
          state_nxt = ARB_STEP;
        end else if (index_pend_r) begin
          state_nxt = ARB_LATCH_INDEX;
        end else if (periodic_pend_r) begin
          state_nxt = ARB_LATCH_PERIODIC;
        end else if (read_pend_r) begin
          state_nxt = ARB_READ;
        end
      end
      ARB_CLEAR,
      ARB_STEP,
      ARB_LATCH_INDEX,
      ARB_LATCH_PERIODIC,
      ARB_READ: state_nxt = ARB_IDLE;
    endcase
  end

  // Arbiter state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ARB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (state_r == ARB_CLEAR) begin
      count_r <= '0;
    end else if (state_r == ARB_STEP) begin
      count_r <= step_dir_r ? count_r + 32'h1 : count_r - 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      present_r   <= '0;
      index_ref_r <= '0;
    end else begin
      if (state_r == ARB_LATCH_PERIODIC) begin
        present_r <= count_r;
      end
      if (state_r == ARB_LATCH_INDEX) begin
        index_ref_r <= count_r;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= '0;
      read_oe   <= 1'h0;
      read_done <= 1'h0;
    end else begin
      read_done <= (state_r == ARB_READ);
      if (state_r == ARB_READ) begin
        read_data <= read_sel_r ? index_ref_r : present_r;
        read_oe   <= 1'h1;
      end else if (read_release) begin
        read_oe <= 1'h0;
      end
    end
  end

endmodule

//--- rtl/encoder_position_capture.sv
// Encoder position capture: trackers, time base, interrupter and decoder.
// Assumes a simple slave-side host interface on pins; all pins are async.
`timescale 1ns/1ns
module encoder_position_capture
  import encoder_capture_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [23:0]             bus_addr,
  input  wire logic                    bus_select_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    latched_write,
  input  wire logic [31:0]             bus_wdata,
  output logic      [31:0]             bus_rdata,
  output logic                         bus_rdata_oe,
  output logic                         bus_ack,
  input  wire logic [5:0]              base_address_switch,
  input  wire logic                    host_bus_reset,
  input  wire logic                    int_ack,
  output logic                         interrupt_request,
  output logic      [7:0]              interrupt_vector,
  input  wire logic [NUM_TRACKERS-1:0] enc_pulse,
  input  wire logic [NUM_TRACKERS-1:0] enc_dir,
  input  wire logic [NUM_SENSORS-1:0]  index_pulse,
  input  wire logic                    ref_10khz,
  input  wire logic                    ref_1hz,
  output logic                         clk_200hz_out,
  output logic                         clk_1khz_out,
  output logic                         clk_1hz_out
);

  logic [SYNC_W-1:0]       async_in;
  logic [SYNC_W-1:0]       meta_r;
  logic [SYNC_W-1:0]       sync_r;
  logic                    s_sel_n;
  logic                    s_wr_n;
  logic [23:0]             s_addr;
  logic                    s_lw;
  logic [31:0]             s_wdata;
  logic [5:0]              s_sw;
  logic                    s_host_bus_reset;
  logic                    s_iack;
  logic [NUM_TRACKERS-1:0] s_pulse;
  logic [NUM_TRACKERS-1:0] s_dir;
  logic [NUM_SENSORS-1:0]  s_index;
  logic                    s_tick;
  logic                    s_pps;

  logic [NUM_TRACKERS-1:0] pulse_prev_r;
  logic [NUM_SENSORS-1:0]  index_prev_r;
  logic                    tick_prev_r;
  logic                    pps_prev_r;
  logic                    iack_prev_r;
  logic                    c200_prev_r;
  logic [NUM_TRACKERS-1:0] step_edge;
  logic [NUM_SENSORS-1:0]  index_edge;
  logic                    tick_edge;
  logic                    pps_edge;
  logic                    iack_edge;
  logic                    periodic_edge;

  logic [5:0]              cnt_200_r;
  logic [3:0]              cnt_1k_r;
  logic [13:0]             cnt_1hz_r;

  logic                    sel_active;
  logic                    in_block;
  logic [3:0]              region;
  logic [3:0]              word;
  logic                    is_write;
  logic                    take;
  logic                    busy_r;
  logic                    arm_r;
  logic                    int_enable_r;
  logic                    irq_pend_r;
  logic [7:0]              vector_r;
  logic [NUM_SENSORS-1:0]  flag_r;
  logic [NUM_SENSORS-1:0]  dir_r;
  logic [NUM_SENSORS-1:0]  flag_clear;
  logic [NUM_TRACKERS-1:0] clear_req;
  logic [NUM_TRACKERS-1:0] read_req;
  logic                    trk_read;
  logic                    read_sel;
  logic [31:0]             local_data_r;
  logic                    local_oe_r;
  logic                    local_ack_due_r;
  logic                    wait_r;
  logic [NUM_TRACKERS-1:0] trk_done;
  logic [NUM_TRACKERS-1:0] trk_oe;
  logic [CNT_W-1:0]        trk_data [NUM_TRACKERS];

  // Two-flop synchroniser for every pin input
  assign async_in = {bus_select_n, write_strobe_n, bus_addr, latched_write, bus_wdata,
                     base_address_switch, host_bus_reset, int_ack, enc_pulse, enc_dir,
                     index_pulse, ref_10khz, ref_1hz};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= SYNC_INIT;
      sync_r <= SYNC_INIT;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign {s_sel_n, s_wr_n, s_addr, s_lw, s_wdata, s_sw, s_host_bus_reset, s_iack,
          s_pulse, s_dir, s_index, s_tick, s_pps} = sync_r;

  // Edge detectors on synchronised levels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_prev_r <= '0;
      index_prev_r <= '0;
      tick_prev_r  <= 1'h0;
      pps_prev_r   <= 1'h0;
      iack_prev_r  <= 1'h0;
      c200_prev_r  <= 1'h0;
    end else begin
      pulse_prev_r <= s_pulse;
      index_prev_r <= s_index;
      tick_prev_r  <= s_tick;
      pps_prev_r   <= s_pps;
      iack_prev_r  <= s_iack;
      c200_prev_r  <= clk_200hz_out;
    end
  end

  assign step_edge     = s_pulse & ~pulse_prev_r;
  assign index_edge    = s_index & ~index_prev_r;
  assign tick_edge     = s_tick & ~tick_prev_r;
  assign pps_edge      = s_pps & ~pps_prev_r;
  assign iack_edge     = s_iack & ~iack_prev_r;
  // 200 Hz rising edge drives latching
  assign periodic_edge = clk_200hz_out & ~c200_prev_r;

  // rising edge of each reference pulse counts once
  // dividers restart on the 1 Hz reference
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_200_r <= '0;
      cnt_1k_r  <= '0;
      cnt_1hz_r <= '0;
    end else if (pps_edge) begin
      cnt_200_r <= '0;
      cnt_1k_r  <= '0;
      cnt_1hz_r <= '0;
    end else if (tick_edge) begin
      cnt_200_r <= (cnt_200_r == DIV_200HZ - 6'h1) ? 6'h0 : cnt_200_r + 6'h1;
      cnt_1k_r  <= (cnt_1k_r == DIV_1KHZ - 4'h1) ? 4'h0 : cnt_1k_r + 4'h1;
      cnt_1hz_r <= (cnt_1hz_r == DIV_1HZ - 14'h1) ? 14'h0 : cnt_1hz_r + 14'h1;
    end
  end

  // 200 Hz clock also driven back out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_200hz_out <= 1'h0;
      clk_1khz_out  <= 1'h0;
      clk_1hz_out   <= 1'h0;
    end else begin
      clk_200hz_out <= (cnt_200_r < HALF_200HZ);
      clk_1khz_out  <= (cnt_1k_r < HALF_1KHZ);
      clk_1hz_out   <= (cnt_1hz_r < HALF_1HZ);
    end
  end

  // switch bits and fixed top byte
  assign in_block = (s_addr[23:16] == ADDR_FIXED_HI) && (s_addr[15:10] == s_sw);
  assign region   = s_addr[9:6];
  assign word     = s_addr[5:2];
  // strobe and latched write qualify writes
  assign is_write   = s_lw & ~s_wr_n;
  assign sel_active = ~s_sel_n;
  assign take       = sel_active & ~busy_r & in_block;
  assign trk_read   = take & ~is_write && (region == REGION_TRACKER)
                      && (word[3:1] < 3'(NUM_TRACKERS));
  // low word bit is the latch select
  assign read_sel   = word[0];

  // reset honoured only right after an arming write
  always_comb begin
    clear_req  = '0;
    read_req   = '0;
    flag_clear = '0;
    for (int t = 0; t < NUM_TRACKERS; t++) begin
      if (trk_read && (word[3:1] == 3'(t))) begin
        read_req[t] = 1'h1;
        if (read_sel) begin
          flag_clear[sensor_of_tracker(t)] = 1'h1;
        end
      end
      if (take && is_write && arm_r && (region == REGION_STATUS) && (word == 4'(t))) begin
        clear_req[t] = 1'h1;
      end
    end
  end

  // arming write, cancelled by any other access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= 1'h0;
    end else if (take) begin
      arm_r <= is_write && (region == REGION_STATUS) && (word == WORD_RESET_ARM);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_enable_r <= INT_ENABLE_RESET;
      vector_r     <= VECTOR_RESET;
    end else if (take && is_write) begin
      if ((region == REGION_STATUS) && (word == WORD_INT_ENABLE)) begin
        int_enable_r <= s_wdata[0];
      end
      if (region == REGION_VECTOR) begin
        vector_r <= s_wdata[7:0];
      end
    end
  end

  assign interrupt_vector = vector_r;

  // one request per 200 Hz period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_r <= 1'h0;
    end else if (s_host_bus_reset) begin
      irq_pend_r <= 1'h0;
    end else if (periodic_edge && int_enable_r) begin
      irq_pend_r <= 1'h1;
    end else if (iack_edge) begin
      irq_pend_r <= 1'h0;
    end
  end

  assign interrupt_request = irq_pend_r;

  // index edge sets flag, set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= '0;
      dir_r  <= '0;
    end else begin
      for (int s = 0; s < NUM_SENSORS; s++) begin
        if (index_edge[s]) begin
          flag_r[s] <= 1'h1;
          dir_r[s]  <= s_dir[tracker_of_sensor(s)];
        end else if (flag_clear[s]) begin
          flag_r[s] <= 1'h0;
        end
      end
    end
  end

  // local read data and access tracking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_r          <= 1'h0;
      local_data_r    <= '0;
      local_oe_r      <= 1'h0;
      local_ack_due_r <= 1'h0;
    end else begin
      local_ack_due_r <= take & ~trk_read;
      if (take) begin
        busy_r <= 1'h1;
      end else if (!sel_active) begin
        busy_r <= 1'h0;
      end
      if (take && !is_write && !trk_read) begin
        local_oe_r <= 1'h1;
        if (region == REGION_STATUS) begin
          for (int s = 0; s < NUM_SENSORS; s++) begin
            local_data_r[2*s]   <= flag_r[s];
            local_data_r[2*s+1] <= dir_r[s];
          end
          local_data_r[31:8] <= '0;
        end else if (region == REGION_VECTOR) begin
          local_data_r <= {24'h0, vector_r};
        end else begin
          local_data_r <= '0;
        end
      end else if (!sel_active) begin
        local_oe_r <= 1'h0;
      end
    end
  end

  // one wait state after tracker read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r  <= 1'h0;
      bus_ack <= 1'h0;
    end else begin
      wait_r <= |trk_done;
      if (!sel_active) begin
        bus_ack <= 1'h0;
      end else if (wait_r || local_ack_due_r) begin
        bus_ack <= 1'h1;
      end
    end
  end

  // select strobe enables latch and buffer
  // drive only under an output enable
  always_comb begin
    bus_rdata = (local_oe_r && sel_active) ? local_data_r : 32'h0;
    for (int t = 0; t < NUM_TRACKERS; t++) begin
      if (trk_oe[t] && sel_active) begin
        bus_rdata = bus_rdata | trk_data[t];
      end
    end
  end

  assign bus_rdata_oe = sel_active & (local_oe_r | (|trk_oe));

  for (genvar g = 0; g < NUM_TRACKERS; g++) begin : g_trk
    encoder_tracker u_trk (
      .clock           (clock),
      .rst_n           (rst_n),
      .step_pulse      (step_edge[g]),
      .step_up         (s_dir[g]),
      .clear_pulse     (clear_req[g]),
      .index_strobe    (index_edge[sensor_of_tracker(g)]),
      .periodic_strobe (periodic_edge),
      .read_req        (read_req[g]),
      .latch_select    (read_sel),
      .read_release    (~sel_active),
      .read_data       (trk_data[g]),
      .read_oe         (trk_oe[g]),
      .read_done       (trk_done[g])
    );
  end

endmodule

//--- verification/encoder_position_capture_checker.sv
// Port-level checks for the encoder position capture block.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/1ns
module encoder_position_capture_checker
  import encoder_capture_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [23:0] bus_addr,
  input wire logic        bus_select_n,
  input wire logic        write_strobe_n,
  input wire logic [31:0] bus_rdata,
  input wire logic        bus_rdata_oe,
  input wire logic        bus_ack,
  input wire logic [5:0]  base_address_switch,
  input wire logic        host_bus_reset,
  input wire logic        interrupt_request,
  input wire logic        clk_200hz_out,
  input wire logic        clk_1khz_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Bus reset held long enough to pass the synchroniser
  sequence s_host_bus_reset;
    host_bus_reset ##1 host_bus_reset ##1 host_bus_reset;
  endsequence
  // Tracker read answered: ack rising in the tracker region
  sequence s_trk_ack;
    $rose(bus_ack) && bus_addr[9:6] == REGION_TRACKER && write_strobe_n;
  endsequence

  // Bus side relations
  property p_float; !bus_rdata_oe |-> bus_rdata == 32'h0; endproperty
  a_float: assert property (p_float) else $error("read data not floated");
  property p_oe_sel; $rose(bus_rdata_oe) |-> !bus_select_n && write_strobe_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output enabled without read select");
  property p_ack_hold; bus_ack && !bus_select_n |=> bus_ack; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_ack_drop; bus_select_n [*4] |-> !bus_ack; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held after release");
  property p_out_blk; !bus_select_n && bus_addr[23:16] != ADDR_FIXED_HI |-> !bus_ack; endproperty
  a_out_blk: assert property (p_out_blk) else $error("ack outside fixed page");
  property p_sw_blk; !bus_select_n && bus_addr[15:10] != base_address_switch |-> !bus_ack; endproperty
  a_sw_blk: assert property (p_sw_blk) else $error("ack outside switch block");
  property p_wait; s_trk_ack |-> $past(bus_rdata_oe) && $stable(bus_rdata); endproperty
  a_wait: assert property (p_wait) else $error("tracker read without wait state");

  // Interrupter and time base
  property p_irq_rst; s_host_bus_reset |=> !interrupt_request; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("interrupt survives bus reset");
  property p_irq_src; $rose(interrupt_request) |-> clk_200hz_out; endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt not from time base");
  property p_clk_hi; $rose(clk_200hz_out) |=> clk_200hz_out [*8]; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("time base high phase too short");
  property p_align; $rose(clk_200hz_out) |-> clk_1khz_out; endproperty
  a_align: assert property (p_align) else $error("time base clocks not aligned");
endmodule

bind encoder_position_capture encoder_position_capture_checker chk (
  .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_select_n(bus_select_n),
  .write_strobe_n(write_strobe_n), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
  .bus_ack(bus_ack), .base_address_switch(base_address_switch), .host_bus_reset(host_bus_reset),
  .interrupt_request(interrupt_request), .clk_200hz_out(clk_200hz_out), .clk_1khz_out(clk_1khz_out));

//--- verification/host_model.sv
// Host computer model: one bus access at a time.
// Assumes calls from the bench; changes pins just after rising edges.
`timescale 1ns/1ns
module host_model (
  input  wire logic        clock,
  input  wire logic        bus_ack,
  input  wire logic [31:0] bus_rdata,
  output logic      [23:0] bus_addr,
  output logic             bus_select_n,
  output logic             write_strobe_n,
  output logic             latched_write,
  output logic      [31:0] bus_wdata
);
  // Idle pins at time zero
  initial begin
    bus_addr = 24'h000000;
    bus_select_n = 1'b1;
    write_strobe_n = 1'b1;
    latched_write = 1'b0;
    bus_wdata = 32'h0;
  end

  // whole 32-bit word
  // Hold request until ack, then release and wait for ack to fall
  task automatic access(input logic wr, input logic [23:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clock);
    bus_addr <= adr;
    bus_wdata <= wd;
    latched_write <= wr;
    write_strobe_n <= !wr;
    bus_select_n <= 1'b0;
    while (ok !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
      ok = bus_ack;
    end
    rd = bus_rdata;
    bus_select_n <= 1'b1;
    write_strobe_n <= 1'b1;
    latched_write <= 1'b0;
    bus_wdata <= ~wd;
    bus_addr <= ~adr;
    for (n = 0; n < 40 && bus_ack !== 1'b0; n++) begin
      @(posedge clock);
    end
  endtask
endmodule

//--- verification/encoder_position_capture_tb.sv
// Self-checking bench for the encoder position capture block.
// Assumes the host model in its own file and the bound checker.
`timescale 1ns/1ns
module encoder_position_capture_tb
  import encoder_capture_pkg::*;
;
  localparam logic [5:0] SW = 6'h15;
  logic        clock, rst_n, write_strobe_n, latched_write, bus_select_n, bus_rdata_oe, bus_ack;
  logic        host_bus_reset, int_ack, interrupt_request, ref_10khz, ref_1hz;
  logic        clk_200hz_out, clk_1khz_out, clk_1hz_out;
  logic [23:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, d;
  logic [7:0]  interrupt_vector;
  logic [4:0]  enc_pulse, enc_dir;
  logic [3:0]  index_pulse;
  logic [2:0]  rc;
  int          num_errors, tests_run;

  encoder_position_capture uut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_select_n(bus_select_n), .write_strobe_n(write_strobe_n), .latched_write(latched_write),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .bus_ack(bus_ack),
    .base_address_switch(SW), .host_bus_reset(host_bus_reset), .int_ack(int_ack),
    .interrupt_request(interrupt_request), .interrupt_vector(interrupt_vector), .enc_pulse(enc_pulse),
    .enc_dir(enc_dir), .index_pulse(index_pulse), .ref_10khz(ref_10khz), .ref_1hz(ref_1hz),
    .clk_200hz_out(clk_200hz_out), .clk_1khz_out(clk_1khz_out), .clk_1hz_out(clk_1hz_out));
  host_model host (.clock(clock), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_select_n(bus_select_n), .write_strobe_n(write_strobe_n), .latched_write(latched_write),
    .bus_wdata(bus_wdata));

  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // reference ticks
  // Scaled 10 KHz tick: every 8 clocks, 2 clocks wide
  always @(posedge clock) begin
    rc <= rc + 3'h1;
    ref_10khz <= (rc < 3'h2);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic host_rd(input logic [9:0] off, output logic [31:0] v);
    logic ok;
    host.access(1'b0, {ADDR_FIXED_HI, SW, off}, 32'h0, v, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic host_wr(input logic [9:0] off, input logic [31:0] v);
    logic ok;
    logic [31:0] x;
    host.access(1'b1, {ADDR_FIXED_HI, SW, off}, v, x, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic steps(input int t, input logic up, input int n);
    enc_dir[t] <= up;
    repeat (n) begin
      repeat (4) @(posedge clock);
      enc_pulse[t] <= 1'b1;
      repeat (4) @(posedge clock);
      enc_pulse[t] <= 1'b0;
    end
    repeat (8) @(posedge clock);
  endtask
  // Wait for a rising 200 Hz edge, then let the latch settle
  task automatic tick();
    logic p;
    p = 1'b1;
    for (int n = 0; n < 900; n++) begin
      @(posedge clock);
      if (p === 1'b0 && clk_200hz_out === 1'b1) break;
      p = clk_200hz_out;
    end
    repeat (12) @(posedge clock);
  endtask

  task automatic t_regs();
    logic ok;
    host_rd(10'h080, d);
    chk({24'h0, d[7:0]}, 32'h0000000f);
    host_wr(10'h080, 32'h000000a5);
    chk({24'h0, interrupt_vector}, 32'h000000a5);
    host_rd(10'h080, d);
    chk({24'h0, d[7:0]}, 32'h000000a5);
    host_rd(10'h000, d);
    chk(d, 32'h0);
    host.access(1'b0, {8'hfe, SW, 10'h080}, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h0);
    host.access(1'b0, {ADDR_FIXED_HI, ~SW, 10'h080}, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_count();
    steps(0, 1'b1, 5);
    tick();
    host_rd(10'h100, d);
    chk(d, 32'h5);
    steps(0, 1'b0, 7);
    tick();
    host_rd(10'h100, d);
    chk(d, 32'hfffffffe);
    host_rd(10'h104, d);
    chk(d, 32'h0);
    $display("test count done");
  endtask
  task automatic t_index();
    steps(3, 1'b0, 3);
    enc_dir[3] <= 1'b1;
    repeat (4) @(posedge clock);
    index_pulse[2] <= 1'b1;
    repeat (4) @(posedge clock);
    index_pulse[2] <= 1'b0;
    repeat (8) @(posedge clock);
    host_rd(10'h0c0, d);
    chk(d, 32'h30);
    host_rd(10'h11c, d);
    chk(d, 32'hfffffffd);
    host_rd(10'h0c0, d);
    chk(d, 32'h20);
    $display("test index done");
  endtask
  task automatic t_reset();
    host_wr(10'h0c0, 32'h0);
    host_wr(10'h0dc, 32'h0);
    host_rd(10'h080, d);
    host_wr(10'h0c0, 32'h0);
    tick();
    host_rd(10'h100, d);
    chk(d, 32'hfffffffe);
    host_wr(10'h0dc, 32'h0);
    host_wr(10'h0c0, 32'h0);
    tick();
    host_rd(10'h100, d);
    chk(d, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_irq();
    tick();
    chk({31'h0, interrupt_request}, 32'h0);
    host_wr(10'h0d8, 32'h1);
    tick();
    chk({31'h0, interrupt_request}, 32'h1);
    int_ack <= 1'b1;
    repeat (4) @(posedge clock);
    int_ack <= 1'b0;
    repeat (4) @(posedge clock);
    chk({31'h0, interrupt_request}, 32'h0);
    tick();
    host_bus_reset <= 1'b1;
    repeat (5) @(posedge clock);
    chk({31'h0, interrupt_request}, 32'h0);
    host_bus_reset <= 1'b0;
    host_wr(10'h0d8, 32'h0);
    tick();
    chk({31'h0, interrupt_request}, 32'h0);
    $display("test irq done");
  endtask
  // A 1 Hz reference pulse in the 200 Hz low phase restarts every divider high
  task automatic t_sync();
    tick();
    repeat (250) @(posedge clock);
    ref_1hz <= 1'b1;
    repeat (8) @(posedge clock);
    ref_1hz <= 1'b0;
    chk({29'h0, clk_200hz_out, clk_1khz_out, clk_1hz_out}, 32'h7);
    $display("test sync done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    host_bus_reset = 1'b0;
    int_ack = 1'b0;
    ref_1hz = 1'b0;
    ref_10khz = 1'b0;
    rc = 3'h0;
    enc_pulse = 5'h0;
    enc_dir = 5'h0;
    index_pulse = 4'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_count();
    t_index();
    t_reset();
    t_irq();
    t_sync();
    give_verdict();
  end
endmodule
